// >>> src/cotc_timing.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "cotc_consts.svh"

// Functional notes
// - falling dead-band select clear: complementary waits falling dead-band count in clock periods.
// - falling dead-band select set: complementary delay counted in delay-chain element periods.
// - after a rising event, falling inputs ignored for rising blanking count.
// - after a falling event, rising inputs ignored for falling blanking count.
// - each rising event postponed by rising phase delay count.
// - each falling event postponed by falling phase delay count.
// - upper two bits of every count register read zero, writes ignored.
// - count fields not cleared by reset; they keep their values.
// - primary delayed by rising dead-band count, clock or chain periods by select.
module cotc_timing #(
  parameter int CNT_W = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire cotc_pkg::cotc_apb_req_t apb_req,
  output cotc_pkg::cotc_apb_rsp_t apb_rsp,
  // generator events and delay-chain tick
  input wire logic rise_event_in,
  input wire logic fall_event_in,
  input wire logic chain_tick_in,
  // output drive
  output cotc_pkg::cotc_drive_t drive_out
);
  initial begin
    if (CNT_W != `COTC_CNT_MSB + 1) $error("cotc_timing: CNT_W must match field width");
  end

  // =========================================
  // registers
  logic [7:0] config_reg;
  logic [CNT_W-1:0] db_rise_reg;
  logic [CNT_W-1:0] db_fall_reg;
  logic [CNT_W-1:0] blk_rise_reg;
  logic [CNT_W-1:0] blk_fall_reg;
  logic [CNT_W-1:0] ph_rise_reg;
  logic [CNT_W-1:0] ph_fall_reg;
  cotc_pkg::cotc_apb_rsp_t rsp_reg;

  logic wr_en;
  logic rd_en;
  logic [11:0] addr;
  logic [CNT_W-1:0] wcnt;
  assign addr = apb_req.paddr;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_reg.pready;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign wcnt = apb_req.pwdata[CNT_W-1:0];

  // count fields have no reset: their value survives every reset
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      if (addr == `COTC_OFF_DB_RISE) begin
        db_rise_reg <= wcnt;
      end else if (addr == `COTC_OFF_DB_FALL) begin
        db_fall_reg <= wcnt;
      end else if (addr == `COTC_OFF_BLK_RISE) begin
        blk_rise_reg <= wcnt;
      end else if (addr == `COTC_OFF_BLK_FALL) begin
        blk_fall_reg <= wcnt;
      end else if (addr == `COTC_OFF_PH_RISE) begin
        ph_rise_reg <= wcnt;
      end else if (addr == `COTC_OFF_PH_FALL) begin
        ph_fall_reg <= wcnt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= `COTC_CFG_RESET;
    end else if (wr_en && addr == `COTC_OFF_CONFIG) begin
      config_reg <= {apb_req.pwdata[7:6], 2'h0, apb_req.pwdata[3:0]};
    end
  end

  // =========================================
  // event path
  // event inputs come from generator logic on this clock, no synchroniser
  logic rise_d_reg;
  logic fall_d_reg;
  logic rise_edge;
  logic fall_edge;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_d_reg <= 1'b0;
      fall_d_reg <= 1'b0;
    end else begin
      rise_d_reg <= rise_event_in;
      fall_d_reg <= fall_event_in;
    end
  end
  assign rise_edge = rise_event_in && !rise_d_reg;
  assign fall_edge = fall_event_in && !fall_d_reg;

  logic blank_rise_busy;
  logic blank_fall_busy;
  logic ph_rise_done;
  logic ph_fall_done;
  logic db_rise_done;
  logic db_fall_done;
  logic rise_take;
  logic fall_take;
  logic rise_tick;
  logic fall_tick;

  // rising blanking hides falling inputs and vice versa
  assign rise_take = rise_edge && !blank_fall_busy;
  assign fall_take = fall_edge && !blank_rise_busy;

  // phase delays sit ahead of blanking start so blanking follows the effective event
  cotc_delay #(.WIDTH(CNT_W)) u_ph_rise (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(rise_take), .tick(1'b1),
    .count(ph_rise_reg), .busy(), .done(ph_rise_done)
  );
  cotc_delay #(.WIDTH(CNT_W)) u_ph_fall (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(fall_take), .tick(1'b1),
    .count(ph_fall_reg), .busy(), .done(ph_fall_done)
  );

  cotc_delay #(.WIDTH(CNT_W)) u_blk_rise (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(ph_rise_done), .tick(1'b1),
    .count(blk_rise_reg), .busy(blank_rise_busy), .done()
  );
  cotc_delay #(.WIDTH(CNT_W)) u_blk_fall (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(ph_fall_done), .tick(1'b1),
    .count(blk_fall_reg), .busy(blank_fall_busy), .done()
  );

  // dead-band ticks: every clock, or one per delay-chain element when selected
  assign rise_tick = config_reg[`COTC_CFG_RDBS_BIT] ? chain_tick_in : 1'b1;
  assign fall_tick = config_reg[`COTC_CFG_FDBS_BIT] ? chain_tick_in : 1'b1;

  cotc_delay #(.WIDTH(CNT_W)) u_db_rise (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(ph_rise_done), .tick(rise_tick),
    .count(db_rise_reg), .busy(), .done(db_rise_done)
  );
  cotc_delay #(.WIDTH(CNT_W)) u_db_fall (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(ph_fall_done), .tick(fall_tick),
    .count(db_fall_reg), .busy(), .done(db_fall_done)
  );

  // =========================================
  // output drive
  // each output drops at once on the opposite event, rises after its dead-band
  logic prim_reg;
  logic comp_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prim_reg <= `COTC_STATE_RESET;
    end else if (ph_fall_done) begin
      prim_reg <= 1'b0;
    end else if (db_rise_done) begin
      prim_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      comp_reg <= `COTC_STATE_RESET;
    end else if (ph_rise_done) begin
      comp_reg <= 1'b0;
    end else if (db_fall_done) begin
      comp_reg <= 1'b1;
    end
  end

  // polarity bits 0 and 1 invert primary and complementary
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_out <= '0;
    end else begin
      drive_out.primary <= prim_reg ^ config_reg[0];
      drive_out.complementary <= comp_reg ^ config_reg[1];
    end
  end

  // =========================================
  // apb read and response: no wait state, data ready at the access phase
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (addr == `COTC_OFF_CONFIG) begin
      rdata = {24'h00_0000, config_reg};
    end else if (addr == `COTC_OFF_DB_RISE) begin
      rdata = {26'h000_0000, db_rise_reg};
    end else if (addr == `COTC_OFF_DB_FALL) begin
      rdata = {26'h000_0000, db_fall_reg};
    end else if (addr == `COTC_OFF_BLK_RISE) begin
      rdata = {26'h000_0000, blk_rise_reg};
    end else if (addr == `COTC_OFF_BLK_FALL) begin
      rdata = {26'h000_0000, blk_fall_reg};
    end else if (addr == `COTC_OFF_PH_RISE) begin
      rdata = {26'h000_0000, ph_rise_reg};
    end else if (addr == `COTC_OFF_PH_FALL) begin
      rdata = {26'h000_0000, ph_fall_reg};
    end else if (addr == `COTC_OFF_STATUS) begin
      rdata = {28'h000_0000, blank_fall_busy, blank_rise_busy, prim_reg, comp_reg};
    end
  end

  logic mapped;
  assign mapped = (addr[1:0] == 2'b00) && (addr <= `COTC_OFF_STATUS);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.pready <= apb_req.psel && !apb_req.penable;
      rsp_reg.pslverr <= apb_req.psel && !apb_req.penable && !mapped;
      if (rd_en) begin
        rsp_reg.prdata <= rdata;
      end
    end
  end
  assign apb_rsp = rsp_reg;
endmodule : cotc_timing

// >>> src/cotc_consts.svh
`ifndef COTC_CONSTS_SVH
`define COTC_CONSTS_SVH
// register byte offsets on the apb slave
`define COTC_OFF_CONFIG 12'h000
`define COTC_OFF_DB_RISE 12'h004
`define COTC_OFF_DB_FALL 12'h008
`define COTC_OFF_BLK_RISE 12'h00C
`define COTC_OFF_BLK_FALL 12'h010
`define COTC_OFF_PH_RISE 12'h014
`define COTC_OFF_PH_FALL 12'h018
`define COTC_OFF_STATUS 12'h01C
// field positions
`define COTC_CNT_MSB 5
`define COTC_CFG_RDBS_BIT 7
`define COTC_CFG_FDBS_BIT 6
`define COTC_CFG_POL_MSB 3
// reset values
`define COTC_CFG_RESET 8'h00
`define COTC_STATE_RESET 1'b0
`endif

// >>> src/cotc_pkg.sv
package cotc_pkg;
  typedef enum logic [1:0] {
    COTC_IDLE = 2'b00,
    COTC_WAIT = 2'b01,
    COTC_FIRE = 2'b10
  } cotc_delay_state_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } cotc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cotc_apb_rsp_t;

  typedef struct packed {
    logic primary;
    logic complementary;
  } cotc_drive_t;
endpackage : cotc_pkg

// >>> src/cotc_delay.sv
`timescale 1ns/1ps
// =========================================
// one-shot delay counter
module cotc_delay #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [WIDTH-1:0] count,
  // result
  output logic busy,
  output logic done
);
  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("cotc_delay: WIDTH out of range");
  end

  cotc_pkg::cotc_delay_state_t state_reg;
  logic [WIDTH-1:0] cnt_reg;

  // zero count fires on the edge after the start, with no wait
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cotc_pkg::COTC_IDLE;
      cnt_reg <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= count;
        if (count == '0) begin
          state_reg <= cotc_pkg::COTC_IDLE;
          done <= 1'b1;
        end else begin
          state_reg <= cotc_pkg::COTC_WAIT;
        end
      end else begin
        case (state_reg)
          cotc_pkg::COTC_WAIT: begin
            if (tick) begin
              if (cnt_reg == WIDTH'(1)) begin
                state_reg <= cotc_pkg::COTC_IDLE;
                done <= 1'b1;
              end
              cnt_reg <= cnt_reg - WIDTH'(1);
            end
          end
          default: state_reg <= cotc_pkg::COTC_IDLE;
        endcase
      end
    end
  end

  assign busy = (state_reg == cotc_pkg::COTC_WAIT);
endmodule : cotc_delay

// >>> test/cotc_timing_props.sv
`timescale 1ns/1ps
// ====================
// apb and register checks
module cotc_timing_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb and events
  input wire cotc_pkg::cotc_apb_req_t apb_req,
  input wire cotc_pkg::cotc_apb_rsp_t apb_rsp,
  input wire logic rise_event_in,
  input wire logic fall_event_in,
  input wire logic chain_tick_in,
  input wire cotc_pkg::cotc_drive_t drive_out
);
  logic setup, rd, cnt, bad;
  assign setup = apb_req.psel && !apb_req.penable;
  assign rd = apb_rsp.pready && !apb_req.pwrite;
  assign cnt = apb_req.paddr >= 12'h004 && apb_req.paddr <= 12'h018;
  assign bad = apb_req.paddr > 12'h01C || apb_req.paddr[1:0] != 2'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  answer_next_a: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  ready_access_a: assert property (apb_rsp.pready |-> apb_req.penable && $past(setup))
    else $error("ready outside access");
  err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  err_unmapped_a: assert property (setup && bad |=> apb_rsp.pslverr)
    else $error("bad address not refused");
  ok_mapped_a: assert property (setup && !bad |=> !apb_rsp.pslverr)
    else $error("good address refused");
  count_upper_a: assert property (rd && cnt |-> apb_rsp.prdata[31:6] == 26'h0)
    else $error("count upper bits set");
  config_upper_a: assert property (rd && apb_req.paddr == 12'h000
    |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("config upper bits set");
  err_zero_a: assert property (rd && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("refused read not zero");
endmodule : cotc_timing_props

bind cotc_timing cotc_timing_props i_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .rise_event_in(rise_event_in),
  .fall_event_in(fall_event_in), .chain_tick_in(chain_tick_in), .drive_out(drive_out));

// >>> test/cotc_timing_bench.sv
`timescale 1ns/1ps
`include "cotc_consts.svh"
module cotc_timing_bench;
  logic ref_clk, reset_n, rise, fall, e;
  logic tick = 1'b0;
  logic [31:0] q;
  int n, n_fail, checked, k;
  int cyc = 0;
  cotc_pkg::cotc_apb_req_t req;
  cotc_pkg::cotc_apb_rsp_t rsp;
  cotc_pkg::cotc_drive_t drv;
  cotc_timing i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
    .rise_event_in(rise), .fall_event_in(fall), .chain_tick_in(tick), .drive_out(drv));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // chain element period of four clocks
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 0);
  end
  // ====================
  // tasks
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    k = 0;
    @(posedge ref_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // the answer is taken at the rising edge that completes the access, then released
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    chk("pready", 1, rsp.pready);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, q);
  endtask : rdc
  task automatic evt(input logic f);
    @(posedge ref_clk);
    if (f) fall <= 1'b1;
    else rise <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((f ? drv.complementary : drv.primary) !== 1'b1 && n < 300);
    chk("opposite", 0, f ? drv.primary : drv.complementary);
    @(posedge ref_clk);
    rise <= 1'b0;
    fall <= 1'b0;
  endtask : evt
  task automatic pair(input logic f, input logic [5:0] ph, input logic [5:0] db);
    apb(1'b1, f ? `COTC_OFF_PH_FALL : `COTC_OFF_PH_RISE, {26'h0, ph});
    apb(1'b1, f ? `COTC_OFF_DB_FALL : `COTC_OFF_DB_RISE, {26'h0, db});
    evt(f);
  endtask : pair
  task automatic blk(input logic f);
    apb(1'b1, f ? `COTC_OFF_BLK_FALL : `COTC_OFF_BLK_RISE, 32'h14);
    evt(f);
    @(posedge ref_clk);
    if (f) rise <= 1'b1;
    else fall <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rise <= 1'b0;
    fall <= 1'b0;
    @(negedge ref_clk);
    chk("blanked", 0, f ? drv.primary : drv.complementary);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, f ? `COTC_OFF_BLK_FALL : `COTC_OFF_BLK_RISE, 32'h0);
  endtask : blk
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // ====================
  // tests
  initial begin
    reset_n = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    req = '0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 4; a <= 24; a += 4) begin
      apb(1'b1, 12'(a), 32'hFFFFFFFF);
      rdc(12'(a), 32'h3F);
      apb(1'b1, 12'(a), 32'h0);
    end
    apb(1'b1, 12'h020, 32'h1);
    chk("pslverr", 1, e);
    rdc(12'h020, 32'h0);
    chk("pslverr", 1, e);
    apb(1'b1, `COTC_OFF_DB_RISE, 32'h15);
    apb(1'b1, `COTC_OFF_CONFIG, 32'h40);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(`COTC_OFF_DB_RISE, 32'h15);
    rdc(`COTC_OFF_CONFIG, 32'h0);
    pair(0, 0, 0);
    chk("latency", 5, n);
    pair(1, 0, 0);
    chk("latency", 5, n);
    pair(0, 7, 9);
    chk("latency", 21, n);
    pair(1, 6, 10);
    chk("latency", 21, n);
    pair(0, 63, 0);
    chk("latency", 68, n);
    apb(1'b1, `COTC_OFF_CONFIG, 32'h40);
    pair(1, 0, 3);
    chk("chain", 1, 32'(n >= 12 && n <= 20));
    apb(1'b1, `COTC_OFF_CONFIG, 32'h0);
    apb(1'b1, `COTC_OFF_PH_RISE, 32'h0);
    blk(0);
    blk(1);
    evt(0);
    chk("latency", 5, n);
    rdc(`COTC_OFF_STATUS, 32'h2);
    apb(1'b1, `COTC_OFF_CONFIG, 32'hFF);
    rdc(`COTC_OFF_CONFIG, 32'hCF);
    @(negedge ref_clk);
    chk("primary", 0, drv.primary);
    chk("complementary", 1, drv.complementary);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
endmodule : cotc_timing_bench
